// ===== asr_clip.sv
// Digital gain, range clipping and output coding of one raw result.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
module asr_clip
	import asr_pkg::*;
(
	// Raw result
	input  wire logic signed [RAW_W-1:0] raw,
	// Settings
	input  wire logic [2:0]              gain_sel,
	input  wire logic                    gain_en,
	input  wire logic                    unipolar,
	input  wire logic                    offset_bin,
	// Coded result
	output logic [CODE_W-1:0]            code,
	output logic                         over,
	output logic                         under
);
	logic signed [EXT_W-1:0] ext;
	logic signed [EXT_W-1:0] scaled;
	logic signed [EXT_W-1:0] hi;
	logic signed [EXT_W-1:0] lo;
	logic signed [EXT_W-1:0] clipped;
	logic [CODE_W-1:0]       flip;

	assign ext = EXT_W'(raw);
	assign scaled = gain_en ? (ext <<< gain_sel) : ext;
	assign hi = unipolar ? UNI_HI : BIP_HI;
	assign lo = unipolar ? UNI_LO : BIP_LO;
	assign over = scaled > hi;
	assign under = scaled < lo;
	assign clipped = over ? hi : (under ? lo : scaled);
	assign flip = (!unipolar && offset_bin) ? CODE_FLIP : '0;
	assign code = clipped[CODE_W-1:0] ^ flip;

endmodule

// ===== asr_host.sv
// Serial host model: drives select, clock and data and samples the line.
// Assumes clk_sys at 50 MHz; one serial bit takes 13 system clocks.
`timescale 1ns/1ps
module asr_host
#(
	parameter int HALF = 6
)
(
	// System clock
	input  wire logic clk_sys,
	// Serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic rdy_dout_o,
	input  wire logic rdy_dout_oe
);
	logic      last_q;
	wire logic line = rdy_dout_oe ? rdy_dout_o : ~last_q;

	// A released line toggles, so a stale bit never passes as data
	always @(posedge clk_sys)
		last_q <= line;

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
		last_q = 1'b0;
	end

	task automatic shift(input logic [23:0] wd, input int n,
		output logic [23:0] rd);
		rd = 24'h0;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge clk_sys);
			din <= wd[i];
			repeat (HALF) @(posedge clk_sys);
			sclk <= 1'b1;
			// Read before this edge's updates land
			rd[i] = line;
			repeat (HALF) @(posedge clk_sys);
			sclk <= 1'b0;
		end
	endtask

	task automatic xfer(input logic [7:0] c, input logic [23:0] wd,
		output logic [23:0] rd);
		logic [23:0] junk;
		int          n;
		n = (c[4:1] inside {[4'h4:4'h8]}) ? 24 : 8;
		rd = 24'h0;
		@(posedge clk_sys);
		cs_n <= 1'b0;
		shift({16'h0, c}, 8, junk);
		if (c[6])
			shift(wd, n, rd);
		repeat (2 * HALF) @(posedge clk_sys);
	endtask
endmodule

// ===== asr_pkg.sv
// Shared constants, field layouts and types of the converter register bank.
// Assumes one system clock; serial pins are synchronised inside the bank.
package asr_pkg;

	// Register select codes
	localparam logic [3:0] RS_STATUS    = 4'h0;
	localparam logic [3:0] RS_CONFIG    = 4'h1;
	localparam logic [3:0] RS_GPIO      = 4'h2;
	localparam logic [3:0] RS_GAINCAL   = 4'h3;
	localparam logic [3:0] RS_RESULT    = 4'h4;
	localparam logic [3:0] RS_SYS_OFS   = 4'h5;
	localparam logic [3:0] RS_SYS_GAIN  = 4'h6;
	localparam logic [3:0] RS_SELF_OFS  = 4'h7;
	localparam logic [3:0] RS_SELF_GAIN = 4'h8;

	// Command byte layout
	localparam int CMD_START_BIT = 7;
	localparam int CMD_MODE_BIT  = 6;
	localparam int CMD_CAL_MSB   = 5;
	localparam int CMD_CAL_LSB   = 4;
	localparam int CMD_IMPD_BIT  = 3;
	localparam int CMD_RATE_MSB  = 2;
	localparam int CMD_RS_MSB    = 4;
	localparam int CMD_RS_LSB    = 1;
	localparam int CMD_READ_BIT  = 0;

	// Transfer lengths in serial clocks
	localparam logic [4:0] CMD_BITS   = 5'h08;
	localparam logic [4:0] SHORT_BITS = 5'h08;
	localparam logic [4:0] LONG_BITS  = 5'h18;
	localparam int         LONG_PAD   = 16;

	// Reset values and writable bits
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] CONFIG_RESET  = 8'h02;
	localparam logic [7:0] CONFIG_WMASK  = 8'hfe;
	localparam logic [7:0] GPIO_RESET    = 8'h0f;
	localparam logic [7:0] GAINCAL_RESET = 8'h1e;
	localparam logic [7:0] GAINCAL_WMASK = 8'hfe;

	// Status bits
	localparam int ST_CALOVR = 7;
	localparam int ST_OVER   = 3;
	localparam int ST_UNDER  = 2;
	localparam int ST_BUSY   = 1;
	localparam int ST_READY  = 0;

	// Config bits
	localparam int CFG_MAINS  = 7;
	localparam int CFG_UNIPOL = 6;
	localparam int CFG_CLKSRC = 5;
	localparam int CFG_REF_BUFFER_ENABLE = 4;
	localparam int CFG_INBUF  = 3;
	localparam int CFG_FORMAT = 2;
	localparam int CFG_SINGLE = 1;

	// Gain and calibration control bits
	localparam int GC_GAIN_MSB  = 7;
	localparam int GC_GAIN_LSB  = 5;
	localparam int GC_SKIP_SG   = 4;
	localparam int GC_SKIP_SO   = 3;
	localparam int GC_SKIP_CG   = 2;
	localparam int GC_SKIP_CO   = 1;

	// Result coding
	localparam int                 RAW_W       = 20;
	localparam int                 EXT_W       = 28;
	localparam int                 CODE_W      = 18;
	localparam int                 CODE_LSB    = 6;
	localparam logic signed [27:0] UNI_HI      = 28'sh003ffff;
	localparam logic signed [27:0] UNI_LO      = 28'sh0000000;
	localparam logic signed [27:0] BIP_HI      = 28'sh001ffff;
	localparam logic signed [27:0] BIP_LO      = 28'shffe0000;
	localparam logic [17:0]        CODE_FLIP   = 18'h20000;
	localparam logic [1:0]         SETTLE_SKIP = 2'h3;

	typedef enum logic [1:0] {SP_CMD, SP_READ, SP_WRITE} asr_spi_state_t;

	typedef struct packed {
		logic       mains_select;
		logic       unipolar;
		logic       clock_source_select;
		logic       ref_buffer_enable;
		logic       input_buffer_enable;
		logic       offset_binary;
		logic       single_shot_select;
		logic [2:0] digital_gain_field;
		logic       skip_sys_gain;
		logic       skip_sys_offset;
		logic       skip_self_gain;
		logic       skip_self_offset;
	} asr_cfg_t;

	typedef struct packed {
		logic [23:0] sys_offset;
		logic [23:0] sys_gain;
		logic [23:0] self_offset;
		logic [23:0] self_gain;
	} asr_coeff_t;

	typedef struct packed {
		logic [1:0] cal;
		logic       power_down;
		logic [2:0] rate;
	} asr_cmd_t;

endpackage

// ===== asr_regs.sv
// Status and control register bank of a delta-sigma converter, reached
// over a serial command-byte link. Assumes the converter core drives the
// busy level and result pulses on clk_sys; the serial pins are async.
`timescale 1ns/1ps
//Function
// - Flag calibration overrange when system gain calibration overranges.
// - Rate bits report the rate of the held result or calibration.
// - Clip results above maximum and raise the overrange flag.
// - Clip results below minimum and raise the underrange flag.
// - Busy flag mirrors modulator activity for conversions and calibrations.
// - Ready flag sets when a new result lands.
// - Read result clears ready at next start; unread keeps it set.
// - Result read during a running conversion clears ready after the read.
// - Mains bit chooses the 50Hz or 60Hz rate set.
// - Polarity bit: one unipolar, zero bipolar range.
// - Clock source bit: one external clock, zero internal oscillator.
// - Reference buffer bit powers or bypasses reference buffers.
// - Input buffer bit powers or bypasses analog input buffers.
// - Bipolar format bit picks two's complement or offset binary.
// - Single-shot bit: one conversion per start, else continuous.
// - First three continuous results after a start are unsettled.
// - End of conversion shows as a high mark then a falling edge on the data line.
// - Gain bits act only on the gain-capable variant.
// - Reset: status all zero, config zero except single-shot one.
// - Gain field codes 0 to 7 give gains 1 to 128.
// - Register access uses command byte with mode bit, select, direction.
// - Writes to the result register are ignored.
module asr_regs
	import asr_pkg::*;
#(
	parameter bit GAIN_CAPABLE = 1'b1
)
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	// Serial pins
	input  wire logic                    cs_n,
	input  wire logic                    sclk,
	input  wire logic                    din,
	output logic                         rdy_dout_o,
	output logic                         rdy_dout_oe,
	// Converter core
	input  wire logic                    mod_busy,
	input  wire logic                    conv_start,
	input  wire logic                    conv_done,
	input  wire logic signed [RAW_W-1:0] conv_raw,
	input  wire logic [2:0]              conv_rate,
	input  wire logic                    cal_done,
	input  wire logic                    sgc_cal_done,
	input  wire logic                    sgc_cal_over,
	// Commands and settings to the core
	output logic                         cmd_valid,
	output asr_cmd_t                     cmd,
	output asr_cfg_t                     cfg,
	output logic [7:0]                   gpio_ctrl,
	output asr_coeff_t                   coeff
);
	logic [2:0]          cs_sync_q;
	logic [2:0]          sclk_sync_q;
	logic [1:0]          din_sync_q;
	asr_spi_state_t      sp_state_q;
	logic [4:0]          bit_cnt_q;
	logic [4:0]          len_q;
	logic [3:0]          rs_q;
	logic [23:0]         shift_in_q;
	logic [23:0]         shift_out_q;
	logic                dout_bit_q;
	logic [7:0]          config_q;
	logic [7:0]          gpio_q;
	logic [7:0]          gaincal_q;
	asr_coeff_t          coeff_q;
	logic [23:0]         result_q;
	logic                ready_q;
	logic                read_seen_q;
	logic                busy_q;
	logic                over_q;
	logic                under_q;
	logic                cal_ovr_q;
	logic [2:0]          rate_q;
	logic [1:0]          settle_q;
	logic                eoc_q;
	logic                cmd_valid_q;
	asr_cmd_t            cmd_q;
	logic                rdy_dout_q;
	logic                rdy_dout_oe_q;

	wire                 cs_act;
	wire                 din_s;
	wire                 sclk_rise;
	wire                 sclk_fall;
	wire [23:0]          shift_nxt;
	wire [4:0]           cnt_nxt;
	wire                 cmd_byte_done;
	wire [7:0]           cmd_byte;
	wire [3:0]           cmd_rs;
	wire                 reg_access;
	wire                 conv_cmd;
	wire                 data_done;
	wire                 wr_commit;
	wire                 result_read;
	wire                 single;
	wire                 accepted;
	wire [CODE_W-1:0]    clip_code;
	wire                 clip_over;
	wire                 clip_under;
	wire [7:0]           status_byte;
	wire [23:0]          rd_word;
	wire                 line_level;
	logic [7:0]          rd_short;
	logic [23:0]         rd_long;

	function automatic logic reg_is_long(input logic [3:0] rs);
		return (rs >= RS_RESULT) && (rs <= RS_SELF_GAIN);
	endfunction

	// Only the second stage of each synchroniser is looked at, except sclk, whose edges compare stages two and three
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_sync_q   <= 3'h7;
			sclk_sync_q <= 3'h0;
			din_sync_q  <= 2'h0;
		end
		else
		begin
			cs_sync_q   <= {cs_sync_q[1:0], cs_n};
			sclk_sync_q <= {sclk_sync_q[1:0], sclk};
			din_sync_q  <= {din_sync_q[0], din};
		end
	end

	assign cs_act    = ~cs_sync_q[1];
	assign din_s     = din_sync_q[1];
	assign sclk_rise = cs_act & sclk_sync_q[1] & ~sclk_sync_q[2];
	assign sclk_fall = cs_act & ~sclk_sync_q[1] & sclk_sync_q[2];
	assign shift_nxt = {shift_in_q[22:0], din_s};
	assign cnt_nxt   = bit_cnt_q + 5'h01;

	assign cmd_byte_done = (sp_state_q == SP_CMD) && sclk_rise &&
		(cnt_nxt == CMD_BITS);
	assign cmd_byte   = shift_nxt[7:0];
	assign cmd_rs     = cmd_byte[CMD_RS_MSB:CMD_RS_LSB];
	assign reg_access = cmd_byte_done && cmd_byte[CMD_START_BIT] &&
		cmd_byte[CMD_MODE_BIT];
	assign conv_cmd   = cmd_byte_done && cmd_byte[CMD_START_BIT] &&
		!cmd_byte[CMD_MODE_BIT];
	assign data_done  = (sp_state_q != SP_CMD) && sclk_rise &&
		(cnt_nxt == len_q);
	assign wr_commit   = data_done && (sp_state_q == SP_WRITE);
	assign result_read = data_done && (sp_state_q == SP_READ) &&
		(rs_q == RS_RESULT);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			sp_state_q <= SP_CMD;
			bit_cnt_q  <= '0;
			len_q      <= SHORT_BITS;
			rs_q       <= RS_STATUS;
			shift_in_q <= '0;
		end
		else if (!cs_act)
		begin
			sp_state_q <= SP_CMD;
			bit_cnt_q  <= '0;
		end
		else if (sclk_rise)
		begin
			shift_in_q <= shift_nxt;
			bit_cnt_q  <= (cmd_byte_done || data_done) ? 5'h00 : cnt_nxt;
			if (reg_access)
			begin
				rs_q       <= cmd_rs;
				len_q      <= reg_is_long(cmd_rs) ? LONG_BITS : SHORT_BITS;
				sp_state_q <= cmd_byte[CMD_READ_BIT] ? SP_READ : SP_WRITE;
			end
			else if (data_done)
				sp_state_q <= SP_CMD;
		end
	end

	// Readback decode; unmapped selects read as zero
	always_comb
	begin
		rd_short = '0;
		if (cmd_rs == RS_STATUS)
			rd_short = status_byte;
		else if (cmd_rs == RS_CONFIG)
			rd_short = config_q;
		else if (cmd_rs == RS_GPIO)
			rd_short = gpio_q;
		else if (cmd_rs == RS_GAINCAL)
			rd_short = gaincal_q;
	end

	always_comb
	begin
		rd_long = '0;
		if (cmd_rs == RS_RESULT)
			rd_long = result_q;
		else if (cmd_rs == RS_SYS_OFS)
			rd_long = coeff_q.sys_offset;
		else if (cmd_rs == RS_SYS_GAIN)
			rd_long = coeff_q.sys_gain;
		else if (cmd_rs == RS_SELF_OFS)
			rd_long = coeff_q.self_offset;
		else if (cmd_rs == RS_SELF_GAIN)
			rd_long = coeff_q.self_gain;
	end

	assign rd_word = reg_is_long(cmd_rs) ? rd_long :
		{rd_short, {LONG_PAD{1'b0}}};

	// Read data changes on the falling serial edge, MSB first
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			shift_out_q <= '0;
			dout_bit_q  <= 1'b0;
		end
		else if (reg_access)
			shift_out_q <= rd_word;
		else if (sclk_fall && (sp_state_q == SP_READ))
		begin
			dout_bit_q  <= shift_out_q[23];
			shift_out_q <= {shift_out_q[22:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			config_q  <= CONFIG_RESET;
			gpio_q    <= GPIO_RESET;
			gaincal_q <= GAINCAL_RESET;
			coeff_q   <= '0;
		end
		else if (wr_commit)
		begin
			if (rs_q == RS_CONFIG)
				config_q <= shift_nxt[7:0] & CONFIG_WMASK;
			else if (rs_q == RS_GPIO)
				gpio_q <= shift_nxt[7:0];
			else if (rs_q == RS_GAINCAL)
				gaincal_q <= shift_nxt[7:0] & GAINCAL_WMASK;
			else if (rs_q == RS_SYS_OFS)
				coeff_q.sys_offset <= shift_nxt;
			else if (rs_q == RS_SYS_GAIN)
				coeff_q.sys_gain <= shift_nxt;
			else if (rs_q == RS_SELF_OFS)
				coeff_q.self_offset <= shift_nxt;
			else if (rs_q == RS_SELF_GAIN)
				coeff_q.self_gain <= shift_nxt;
		end
	end

	assign single = config_q[CFG_SINGLE];

	asr_clip u_clip (
		.raw        (conv_raw),
		.gain_sel   (gaincal_q[GC_GAIN_MSB:GC_GAIN_LSB]),
		.gain_en    (GAIN_CAPABLE),
		.unipolar   (config_q[CFG_UNIPOL]),
		.offset_bin (config_q[CFG_FORMAT]),
		.code       (clip_code),
		.over       (clip_over),
		.under      (clip_under)
	);

	assign accepted = conv_done && (single || (settle_q == SETTLE_SKIP));

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			settle_q <= '0;
		else if (conv_cmd)
			settle_q <= '0;
		else if (conv_done && !single && (settle_q != SETTLE_SKIP))
			settle_q <= settle_q + 2'h1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			result_q <= '0;
			over_q   <= 1'b0;
			under_q  <= 1'b0;
		end
		else if (accepted)
		begin
			result_q <= {clip_code, {CODE_LSB{1'b0}}};
			over_q   <= clip_over;
			under_q  <= clip_under;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ready_q     <= 1'b0;
			read_seen_q <= 1'b0;
		end
		else
		begin
			ready_q <= accepted || (ready_q &&
				!(conv_start && read_seen_q) &&
				!(result_read && mod_busy));
			if (accepted)
				read_seen_q <= 1'b0;
			else if (result_read)
				read_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_q    <= 1'b0;
			cal_ovr_q <= 1'b0;
			rate_q    <= '0;
			eoc_q     <= 1'b0;
		end
		else
		begin
			busy_q <= mod_busy;
			eoc_q  <= accepted;
			if (sgc_cal_done)
				cal_ovr_q <= sgc_cal_over;
			if (accepted || cal_done)
				rate_q <= conv_rate;
		end
	end

	assign status_byte = {cal_ovr_q, rate_q, over_q, under_q, busy_q,
		ready_q};

	// high mark then low when ready
	assign line_level = (sp_state_q == SP_READ) ? dout_bit_q :
		(eoc_q | ~ready_q);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rdy_dout_q    <= 1'b1;
			rdy_dout_oe_q <= 1'b0;
			cmd_valid_q   <= 1'b0;
			cmd_q         <= '0;
		end
		else
		begin
			rdy_dout_q    <= line_level;
			rdy_dout_oe_q <= cs_act;
			cmd_valid_q   <= conv_cmd;
			if (conv_cmd)
				cmd_q <= {cmd_byte[CMD_CAL_MSB:CMD_CAL_LSB],
					cmd_byte[CMD_IMPD_BIT], cmd_byte[CMD_RATE_MSB:0]};
		end
	end

	assign rdy_dout_o  = rdy_dout_q;
	assign rdy_dout_oe = rdy_dout_oe_q;
	assign cmd_valid   = cmd_valid_q;
	assign cmd         = cmd_q;
	assign gpio_ctrl   = gpio_q;
	assign coeff       = coeff_q;
	assign cfg = '{
		mains_select:        config_q[CFG_MAINS],
		unipolar:            config_q[CFG_UNIPOL],
		clock_source_select: config_q[CFG_CLKSRC],
		ref_buffer_enable:   config_q[CFG_REF_BUFFER_ENABLE],
		input_buffer_enable: config_q[CFG_INBUF],
		offset_binary:       config_q[CFG_FORMAT],
		single_shot_select:  config_q[CFG_SINGLE],
		digital_gain_field:  gaincal_q[GC_GAIN_MSB:GC_GAIN_LSB],
		skip_sys_gain:       gaincal_q[GC_SKIP_SG],
		skip_sys_offset:     gaincal_q[GC_SKIP_SO],
		skip_self_gain:      gaincal_q[GC_SKIP_CG],
		skip_self_offset:    gaincal_q[GC_SKIP_CO]
	};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_eoc_idle;
		accepted && (sp_state_q == SP_CMD) ##1 (sp_state_q == SP_CMD);
	endsequence

	property p_ready_set;
		accepted |=> ready_q;
	endproperty
	a_ready_set: assert property (p_ready_set)
		else $error("ready not set by new result");

	property p_over;
		accepted && clip_over |=> over_q && !under_q;
	endproperty
	a_over: assert property (p_over)
		else $error("overrange flag wrong");

	property p_under;
		accepted && clip_under |=> under_q && !over_q;
	endproperty
	a_under: assert property (p_under)
		else $error("underrange flag wrong");

	property p_busy;
		##1 status_byte[ST_BUSY] == $past(mod_busy);
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy flag does not follow modulator");

	property p_ready_start_clear;
		ready_q && read_seen_q && conv_start && !accepted |=> !ready_q;
	endproperty
	a_ready_start_clear: assert property (p_ready_start_clear)
		else $error("ready kept after read and start");

	property p_ready_hold;
		ready_q && !read_seen_q && !result_read |=> ready_q;
	endproperty
	a_ready_hold: assert property (p_ready_hold)
		else $error("unread ready lost");

	property p_ready_read_busy;
		result_read && mod_busy && !accepted |=> !ready_q;
	endproperty
	a_ready_read_busy: assert property (p_ready_read_busy)
		else $error("ready kept after read during conversion");

	property p_result_nowrite;
		wr_commit && (rs_q == RS_RESULT) && !accepted |=> $stable(result_q);
	endproperty
	a_result_nowrite: assert property (p_result_nowrite)
		else $error("result register changed by write");

	property p_cfg_write;
		wr_commit && (rs_q == RS_CONFIG) |=>
			config_q == ($past(shift_nxt[7:0]) & CONFIG_WMASK);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("config write not stored");

	property p_rate;
		accepted || cal_done |=> rate_q == $past(conv_rate);
	endproperty
	a_rate: assert property (p_rate)
		else $error("rate bits not updated");

	property p_cal_ovr;
		sgc_cal_done && sgc_cal_over |=> status_byte[ST_CALOVR];
	endproperty
	a_cal_ovr: assert property (p_cal_ovr)
		else $error("calibration overrange not flagged");

	property p_settle;
		conv_done && !single && (settle_q != SETTLE_SKIP) |=>
			$stable(result_q) && $stable(ready_q);
	endproperty
	a_settle: assert property (p_settle)
		else $error("unsettled result taken");

	property p_eoc;
		s_eoc_idle |=> rdy_dout_q ##1 !rdy_dout_q;
	endproperty
	a_eoc: assert property (p_eoc)
		else $error("no end of conversion mark");

endmodule

// ===== asr_regs_test.sv
// Self-checking bench of the converter register bank behind a serial host.
// Assumes asr_pkg, asr_regs and asr_host are compiled before it.
`timescale 1ns/1ps
module asr_regs_test
	import asr_pkg::*;
;
	logic                    clk_sys = 1'b0;
	logic                    nrst = 1'b0;
	logic                    mod_busy = 1'b0;
	logic                    conv_start = 1'b0;
	logic                    conv_done = 1'b0;
	logic signed [RAW_W-1:0] conv_raw = '0;
	logic [2:0]              conv_rate = 3'h0;
	logic                    cal_done = 1'b0;
	logic                    sgc_cal_done = 1'b0;
	logic                    sgc_cal_over = 1'b0;
	logic                    cs_n, sclk, din, rdy_dout_o, rdy_dout_oe;
	logic                    cmd_valid;
	asr_cmd_t                cmd;
	asr_cfg_t                cfg;
	logic [7:0]              gpio_ctrl, c, g;
	asr_coeff_t              coeff;
	int                      bad_count, comparisons, n_cmd, seed;
	logic [2:0]              rt;
	logic [19:0]             e, r;
	logic [23:0]             v, u;
	logic [3:0]              rsl[5] = '{4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
	// Corner raws sit on each bipolar limit and one code beyond every limit
	logic [7:0]              kc[6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h42, 8'h42};
	logic [19:0]             kr[6] = '{20'h1ffff, 20'h20000, 20'he0000,
		20'hdffff, 20'hfffff, 20'h40000};

	always #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
		if (cmd_valid === 1'b1)
			n_cmd++;

	asr_regs asr_regs_inst (.clk_sys, .nrst, .cs_n, .sclk, .din, .rdy_dout_o,
		.rdy_dout_oe, .mod_busy, .conv_start, .conv_done, .conv_raw,
		.conv_rate, .cal_done, .sgc_cal_done, .sgc_cal_over, .cmd_valid,
		.cmd, .cfg, .gpio_ctrl, .coeff);

	asr_host asr_host_inst (.clk_sys, .cs_n, .sclk, .din, .rdy_dout_o,
		.rdy_dout_oe);

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string nm, input logic [23:0] ex,
		input logic [23:0] got);
		comparisons++;
		if (got !== ex)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic rd(input logic [3:0] rs, input logic [23:0] ex,
		input string nm);
		logic [23:0] got;
		asr_host_inst.xfer({3'b110, rs, 1'b1}, 24'h0, got);
		check(nm, ex, got);
	endtask

	task automatic wr(input logic [3:0] rs, input logic [23:0] d);
		logic [23:0] got;
		asr_host_inst.xfer({3'b110, rs, 1'b0}, d, got);
	endtask

	task automatic conv(input logic [19:0] x, input logic acc);
		logic seen;
		seen = 1'b0;
		@(posedge clk_sys);
		conv_raw <= x;
		conv_rate <= rt;
		conv_done <= 1'b1;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		repeat (4)
		begin
			@(posedge clk_sys);
			seen = seen | rdy_dout_o;
		end
		if (acc)
		begin
			check("eoc mark", 24'h1, seen);
			check("ready line", 24'h0, rdy_dout_o);
			check("line enable", 24'h1, rdy_dout_oe);
		end
	endtask

	task automatic pulse_start;
		@(posedge clk_sys);
		conv_start <= 1'b1;
		@(posedge clk_sys);
		conv_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Returns {over, under, code} for the current config and gain
	function automatic logic [19:0] model(input logic [19:0] x);
		logic signed [27:0] y, hi, lo;
		logic [19:0]        q;
		y = 28'(signed'(x));
		y = y <<< g[7:5];
		hi = c[6] ? UNI_HI : BIP_HI;
		lo = c[6] ? UNI_LO : BIP_LO;
		if (y > hi)
			q = {2'b10, hi[17:0]};
		else if (y < lo)
			q = {2'b01, lo[17:0]};
		else
			q = {2'b00, y[17:0]};
		if (!c[6] && c[2])
			q[17] = ~q[17];
		return q;
	endfunction

	function automatic logic [23:0] stat(input logic b, input logic y);
		return {16'h0, 1'b1, rt, e[19:18], b, y};
	endfunction

	initial
	begin
		repeat (90000) @(posedge clk_sys);
		bad_count++;
		complete_run;
	end

	initial
	begin
		seed = 94;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("line enable", 24'h0, rdy_dout_oe);
		rd(RS_STATUS, {16'h0, STATUS_RESET}, "status reset");
		rd(RS_CONFIG, 24'h2, "config reset");
		rd(RS_GAINCAL, 24'h1e, "gaincal reset");
		rd(RS_RESULT, 24'h0, "result reset");
		wr(RS_RESULT, 24'h5a5a5a);
		wr(RS_STATUS, 24'hff);
		rd(RS_RESULT, 24'h0, "result write");
		rd(RS_STATUS, 24'h0, "status write");
		rd(4'h9, 24'h0, "unmapped");
		foreach (rsl[k])
		begin
			v = 24'($random(seed));
			if (rsl[k] == RS_GPIO)
				v[23:8] = 16'h0;
			wr(rsl[k], v);
			rd(rsl[k], v, "coefficient");
			u = rsl[k] == RS_GPIO ? {16'h0, gpio_ctrl} :
				coeff[(8 - rsl[k]) * 24 +: 24];
			check("register out", v, u);
		end
		check("coeff out", v, coeff.self_gain);
		rt = 3'h5;
		@(posedge clk_sys);
		conv_rate <= rt;
		cal_done <= 1'b1;
		sgc_cal_done <= 1'b1;
		sgc_cal_over <= 1'b1;
		@(posedge clk_sys);
		cal_done <= 1'b0;
		sgc_cal_done <= 1'b0;
		rd(RS_STATUS, 24'hd0, "cal status");
		for (int i = 0; i < 14; i++)
		begin
			c = i < 6 ? kc[i] : 8'($random(seed)) | 8'h02;
			g = i < 6 ? 8'h1e : 8'($random(seed));
			c[0] = 1'b0;
			g[0] = 1'b0;
			rt = 3'($random(seed));
			r = i < 6 ? kr[i] : 20'($random(seed));
			wr(RS_CONFIG, {16'h0, c | 8'h01});
			rd(RS_CONFIG, {16'h0, c}, "config");
			wr(RS_GAINCAL, {16'h0, g | 8'h01});
			rd(RS_GAINCAL, {16'h0, g}, "gaincal");
			check("cfg out", {c[7:1], g[7:1]}, cfg);
			e = model(r);
			conv(r, 1'b1);
			rd(RS_STATUS, stat(1'b0, 1'b1), "status");
			rd(RS_RESULT, {e[17:0], 6'h0}, "result");
		end
		pulse_start;
		rd(RS_STATUS, stat(1'b0, 1'b0), "start clears");
		r = 20'h0;
		e = model(r);
		conv(r, 1'b1);
		pulse_start;
		rd(RS_STATUS, stat(1'b0, 1'b1), "unread keeps");
		mod_busy <= 1'b1;
		rd(RS_STATUS, stat(1'b1, 1'b1), "busy");
		rd(RS_RESULT, {e[17:0], 6'h0}, "busy result");
		rd(RS_STATUS, stat(1'b1, 1'b0), "read clears");
		mod_busy <= 1'b0;
		rd(RS_STATUS, stat(1'b0, 1'b0), "idle");
		wr(RS_CONFIG, 24'h0);
		r = 20'($random(seed));
		asr_host_inst.xfer({2'b10, r[5:0]}, 24'h0, u);
		check("random command", {18'h0, r[5:0]}, cmd);
		v = 24'(n_cmd);
		asr_host_inst.xfer(8'h83, 24'h0, u);
		check("command", 24'h3, cmd);
		check("command count", v + 24'h1, 24'(n_cmd));
		repeat (3)
			conv(20'h00100, 1'b0);
		rd(RS_STATUS, stat(1'b0, 1'b0), "unsettled ready");
		rd(RS_RESULT, {e[17:0], 6'h0}, "unsettled");
		c = 8'h00;
		r = 20'h00200;
		e = model(r);
		conv(r, 1'b1);
		rd(RS_RESULT, {e[17:0], 6'h0}, "settled");
		// Second reset in mid-run, select still held low by the host
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(RS_STATUS, {16'h0, STATUS_RESET}, "status reset again");
		rd(RS_CONFIG, {16'h0, CONFIG_RESET}, "config reset again");
		complete_run;
	end
endmodule
